/* File: asc_pkg.sv */
// Constants, types and register map of the converter status/control block.
// Assumes a classic Wishbone master and a converter core that reports events.
// How it works
// (R1) Battery enable routes battery quarter voltage to internal inputs eighteen and sixteen.
// (R2) Battery and temperature both enabled: only battery reaches the shared input.
// (R3) Interrupt when any end, injected end, monitor or overrun flag meets enable.
// (R4) Regular and injected start flags never raise the interrupt.
// (R5) Software writes only full words; reads may be any size.
// (R6) Overrun flag set on lost data, only while DMA mode or granularity set.
// (R7) Regular start flag set when regular conversion begins, held until cleared.
// (R8) Injected start flag set when injected group begins, held until cleared.
// (R9) Injected end flag set only after last injected channel finishes.
// (R10) Regular end flag cleared by software write or result register read.
// (R11) Monitor flag set when guarded value leaves low/high threshold window.
// (R12) Overrun enable set: overrun flag raises the interrupt.
// (R13) Resolution code selects 12/10/8/6 bits and 15/13/11/9 cycles minimum.
// (R14) Separate monitor enables for regular and injected conversions.
// (R15) Discontinuous trigger converts count field plus one regular channels.
// (R16) Bit 11 regular, bit 12 injected discontinuous mode enables.
// (R17) Auto injection starts injected group after regular group completes.
// (R18) Single-channel bit clear: monitor all; set: only selected channel.
// (R19) Scan bit converts every listed sequence input in turn.
// (R20) Regular end per sequence when granularity zero, per conversion when one.
// (R21) Injected end interrupt only after last channel and with enable.
// (R22) Monitor channel field selects input 0 to 18; higher codes reserved.
// (R23) Granularity bit 10: per-conversion end with overrun check, or per sequence.
// (R24) Overrun in DMA mode blocks DMA, aborts regular conversion, ignores triggers.
// (R25) Writing zero clears a flag, writing one leaves it unchanged.
// (R26) Interrupt is a level held while any enabled flag stays set.
package asc_pkg;

    // ========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] FLAGS_OFS  = 8'h00;
    localparam logic [7:0] CTRL1_OFS  = 8'h04;
    localparam logic [7:0] MODE_OFS   = 8'h08;
    localparam logic [7:0] COMMON_OFS = 8'h0c;
    localparam logic [7:0] RESULT_OFS = 8'h10;
    localparam logic [7:0] LOWTH_OFS  = 8'h14;
    localparam logic [7:0] HIGHTH_OFS = 8'h18;

    // ========================================================
    // Reset values and masks
    localparam logic [31:0] FLAGS_RST  = 32'h0000_0000;
    localparam logic [31:0] CTRL1_RST  = 32'h0000_0000;
    localparam logic [31:0] CTRL1_MASK = 32'h07c0_ffff;
    localparam logic [11:0] HIGHTH_RST = 12'hfff;

    // ========================================================
    // Flag positions
    localparam int F_MON = 0;
    localparam int F_EOC = 1;
    localparam int F_INJECTED_END_FLAG = 2;
    localparam int F_INJECTED_START_FLAG = 3;
    localparam int F_REGULAR_START_FLAG = 4;
    localparam int F_OVR = 5;

    // ========================================================
    // Control one fields
    localparam int C_CH_LO = 0;
    localparam int C_REGULAR_END_IRQ_ENABLE = 5;
    localparam int C_MONIE = 6;
    localparam int C_INJECTED_END_IRQ_ENABLE = 7;
    localparam int C_SCAN = 8;
    localparam int C_SGL = 9;
    localparam int C_AUTO = 10;
    localparam int C_DISC = 11;
    localparam int C_JDISC = 12;
    localparam int C_DNUM_LO = 13;
    localparam int C_JMON = 22;
    localparam int C_MON = 23;
    localparam int C_RES_LO = 24;
    localparam int C_OVERRUN_IRQ_ENABLE = 26;

    // Mode register and common register fields
    localparam int M_DMA = 8;
    localparam int M_END_FLAG_GRANULARITY = 10;
    localparam int K_BAT = 0;
    localparam int K_TEMP = 1;

    // ========================================================
    // Numbers
    localparam logic [4:0] MAX_CHANNEL = 5'h12;
    localparam logic [4:0] CONV_BASE_CYCLES = 5'h03;
    localparam logic [4:0] FULL_BITS = 5'h0c;
    localparam logic [4:0] BITS_STEP = 5'h02;

    typedef enum logic [2:0] {
        R_FLAGS  = 3'b000,
        R_CTRL1  = 3'b001,
        R_MODE   = 3'b010,
        R_COMMON = 3'b011,
        R_RESULT = 3'b100,
        R_LOWTH  = 3'b101,
        R_HIGHTH = 3'b110,
        R_NONE   = 3'b111
    } asc_reg_t;

    // Events reported by the converter core
    typedef struct packed {
        logic        reg_start;
        logic        inj_start;
        logic        reg_done;
        logic        reg_last;
        logic        inj_done;
        logic        inj_last;
        logic        dma_ack;
        logic [4:0]  channel;
        logic [11:0] data;
    } asc_event_t;

    // Configuration handed to the converter core
    typedef struct packed {
        logic [4:0] result_bits;
        logic [4:0] min_cycles;
        logic       scan;
        logic       reg_disc;
        logic       inj_disc;
        logic [3:0] disc_len;
        logic       battery_route;
        logic       temp_route;
        logic       reg_halt;
        logic       dma_req;
        logic       auto_inj_start;
    } asc_config_t;

    // Result bits per resolution code
    function automatic logic [4:0] res_bits(input logic [1:0] code);
        res_bits = 5'(FULL_BITS - 5'(code) * BITS_STEP);
    endfunction

    // Register decode, shared by read and write paths
    function automatic asc_reg_t reg_decode(input logic [7:0] adr);
        unique case (adr)
            FLAGS_OFS:  reg_decode = R_FLAGS;
            CTRL1_OFS:  reg_decode = R_CTRL1;
            MODE_OFS:   reg_decode = R_MODE;
            COMMON_OFS: reg_decode = R_COMMON;
            RESULT_OFS: reg_decode = R_RESULT;
            LOWTH_OFS:  reg_decode = R_LOWTH;
            HIGHTH_OFS: reg_decode = R_HIGHTH;
            default:    reg_decode = R_NONE;
        endcase
    endfunction

endpackage

/* File: asc_status_control.sv */
// Flags, first control register and interrupt of the converter.
// Assumes a classic Wishbone master and a core that pulses its events.
`timescale 1ns/1ps
module asc_status_control
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    // Wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // Converter core
    input  wire asc_event_t  I_CONV_EVT,
    output asc_config_t      O_CONV_CFG,
    // Interrupt
    output logic             O_IRQ
);

    // ========================================================
    // State
    typedef struct packed {
        logic [5:0]  flags;
        logic [31:0] ctrl1;
        logic        dma_mode;
        logic        end_flag_granularity;
        logic        bat_en;
        logic        temp_en;
        logic [11:0] result;
        logic        pending;
        logic        halt;
        logic [11:0] low_th;
        logic [11:0] high_th;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
        asc_config_t cfg;
    } asc_state_t;

    asc_state_t s;
    asc_state_t next_s;

    // ========================================================
    // Next state
    always_comb begin
        logic       acc;
        logic       wr;
        logic       rd;
        asc_reg_t   sel_reg;
        logic [5:0] set;
        logic [5:0] clr;
        logic       reg_ok;
        logic       lost;
        logic       ch_ok;
        logic       guard;
        logic       outside;
        logic [1:0] res;

        next_s = s;
        acc = I_WB_CYC && I_WB_STB && !s.ack;
        // Partial writes are dropped: the register file is word-written only
        wr = acc && I_WB_WE && (I_WB_SEL == 4'hf);  // see (R5)
        rd = acc && !I_WB_WE;
        sel_reg = reg_decode(I_WB_ADR);
        set = 6'h00;
        clr = 6'h00;
        reg_ok = 1'b0;
        lost = 1'b0;
        ch_ok = 1'b0;
        guard = 1'b0;
        outside = 1'b0;
        res = 2'b00;

        // Bus answer: ack registered one cycle after the request, drops the cycle after
        next_s.ack = acc;
        next_s.dat = 32'h0000_0000;
        if (rd) begin
            unique case (sel_reg)
                R_FLAGS:  next_s.dat = {26'h0000000, s.flags};
                R_CTRL1:  next_s.dat = s.ctrl1;
                R_MODE:   next_s.dat = 32'(s.dma_mode) << M_DMA | 32'(s.end_flag_granularity) << M_END_FLAG_GRANULARITY;
                R_COMMON: next_s.dat = 32'(s.bat_en) << K_BAT | 32'(s.temp_en) << K_TEMP;
                R_RESULT: next_s.dat = {20'h00000, s.result};
                R_LOWTH:  next_s.dat = {20'h00000, s.low_th};
                R_HIGHTH: next_s.dat = {20'h00000, s.high_th};
                R_NONE:   next_s.dat = 32'h0000_0000;
            endcase
        end

        // Software writes
        if (wr) begin
            unique case (sel_reg)
                R_FLAGS:  clr = ~I_WB_DAT[5:0];  // see (R25)
                R_CTRL1:  next_s.ctrl1 = I_WB_DAT & CTRL1_MASK;
                R_MODE: begin
                    next_s.dma_mode = I_WB_DAT[M_DMA];
                    next_s.end_flag_granularity = I_WB_DAT[M_END_FLAG_GRANULARITY];
                end
                R_COMMON: begin
                    next_s.bat_en = I_WB_DAT[K_BAT];
                    next_s.temp_en = I_WB_DAT[K_TEMP];
                end
                R_LOWTH:  next_s.low_th = I_WB_DAT[11:0];
                R_HIGHTH: next_s.high_th = I_WB_DAT[11:0];
                R_RESULT, R_NONE: ;
            endcase
        end
        // Reading the result consumes it
        if (rd && sel_reg == R_RESULT) begin
            clr[F_EOC] = 1'b1;  // see (R10)
            next_s.pending = 1'b0;
        end
        if (I_CONV_EVT.dma_ack) begin
            next_s.pending = 1'b0;
        end

        // Regular events are ignored while halted after a DMA overrun
        reg_ok = !s.halt;  // see (R24)
        if (I_CONV_EVT.reg_start && reg_ok) begin
            set[F_REGULAR_START_FLAG] = 1'b1;  // see (R7)
        end
        if (I_CONV_EVT.inj_start) begin
            set[F_INJECTED_START_FLAG] = 1'b1;  // see (R8)
        end

        // Data lost: a new result while the previous one is unread
        lost = I_CONV_EVT.reg_done && reg_ok && s.pending && (s.dma_mode || s.end_flag_granularity);
        if (lost) begin
            set[F_OVR] = 1'b1;  // see (R6) (R23)
            if (s.dma_mode) begin
                next_s.halt = 1'b1;  // see (R24)
            end
        end
        if (I_CONV_EVT.reg_done && reg_ok && !lost) begin
            next_s.result = I_CONV_EVT.data;
            next_s.pending = 1'b1;
            if (s.end_flag_granularity || I_CONV_EVT.reg_last) begin
                set[F_EOC] = 1'b1;  // see (R20) (R23)
            end
        end
        if (I_CONV_EVT.inj_done && I_CONV_EVT.inj_last) begin
            set[F_INJECTED_END_FLAG] = 1'b1;  // see (R9) (R21)
        end

        // Window monitor
        ch_ok = !s.ctrl1[C_SGL]
                || (I_CONV_EVT.channel == s.ctrl1[C_CH_LO +: 5]
                    && s.ctrl1[C_CH_LO +: 5] <= MAX_CHANNEL);  // see (R18) (R22)
        guard = (I_CONV_EVT.reg_done && reg_ok && s.ctrl1[C_MON])
                || (I_CONV_EVT.inj_done && s.ctrl1[C_JMON]);  // see (R14)
        outside = I_CONV_EVT.data < s.low_th || I_CONV_EVT.data > s.high_th;
        if (guard && ch_ok && outside) begin
            set[F_MON] = 1'b1;  // see (R11)
        end

        // Set beats a clear in the same cycle
        next_s.flags = (s.flags & ~clr) | set;
        // Recovery from a DMA overrun is clearing the overrun flag
        if (s.halt && !next_s.flags[F_OVR]) begin
            next_s.halt = 1'b0;
        end

        // Level interrupt; start flags take no part
        next_s.irq = (next_s.flags[F_EOC] && next_s.ctrl1[C_REGULAR_END_IRQ_ENABLE])
                   || (next_s.flags[F_INJECTED_END_FLAG] && next_s.ctrl1[C_INJECTED_END_IRQ_ENABLE])
                   || (next_s.flags[F_MON] && next_s.ctrl1[C_MONIE])
                   || (next_s.flags[F_OVR] && next_s.ctrl1[C_OVERRUN_IRQ_ENABLE]);  // see (R3) (R4) (R12) (R26)

        // Configuration to the core
        res = next_s.ctrl1[C_RES_LO +: 2];
        next_s.cfg.result_bits = res_bits(res);  // see (R13)
        next_s.cfg.min_cycles = 5'(res_bits(res) + CONV_BASE_CYCLES);  // see (R13)
        next_s.cfg.scan = next_s.ctrl1[C_SCAN];  // see (R19)
        next_s.cfg.reg_disc = next_s.ctrl1[C_DISC];  // see (R16)
        next_s.cfg.inj_disc = next_s.ctrl1[C_JDISC];  // see (R16)
        next_s.cfg.disc_len = 4'(next_s.ctrl1[C_DNUM_LO +: 3]) + 4'h1;  // see (R15)
        next_s.cfg.battery_route = next_s.bat_en;  // see (R1)
        next_s.cfg.temp_route = next_s.temp_en && !next_s.bat_en;  // see (R2)
        next_s.cfg.reg_halt = next_s.halt;  // see (R24)
        next_s.cfg.dma_req = I_CONV_EVT.reg_done && reg_ok && !lost && s.dma_mode;
        next_s.cfg.auto_inj_start = I_CONV_EVT.reg_done && reg_ok && I_CONV_EVT.reg_last
                                    && s.ctrl1[C_AUTO];  // see (R17)
    end

    // ========================================================
    // Registers
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            s <= '0;
            s.flags <= FLAGS_RST[5:0];
            s.ctrl1 <= CTRL1_RST;
            s.high_th <= HIGHTH_RST;
            s.cfg.result_bits <= FULL_BITS;
            s.cfg.min_cycles <= 5'(FULL_BITS + CONV_BASE_CYCLES);
            s.cfg.disc_len <= 4'h1;
        end else begin
            s <= next_s;
        end
    end

    assign O_WB_DAT = s.dat;
    assign O_WB_ACK = s.ack;
    assign O_CONV_CFG = s.cfg;
    assign O_IRQ = s.irq;

endmodule

/* File: asc_status_control_asserts.sv */
// Port-level checks for the converter flags, control and interrupt block.
// Assumes binding to asc_status_control; one clock, synchronous reset.
`timescale 1ns/1ps
module asc_status_control_asserts
    import asc_pkg::*;
(
    // Clock and reset
    input wire logic        I_CORE_CLK,
    input wire logic        I_RST,
    // Bus
    input wire logic        I_WB_CYC,
    input wire logic        I_WB_STB,
    input wire logic        I_WB_WE,
    input wire logic [7:0]  I_WB_ADR,
    input wire logic [3:0]  I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [31:0] O_WB_DAT,
    input wire logic        O_WB_ACK,
    // Core and interrupt
    input wire asc_event_t  I_CONV_EVT,
    input wire asc_config_t O_CONV_CFG,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);
    // ========
    // Bus answer
    AST_ACK_NEXT: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
        else $error("read data not zero outside ack");
    // ========
    // Interrupt and core outputs
    AST_IRQ_CAUSE: assert property ($rose(O_IRQ) |-> $past(I_CONV_EVT.reg_done
        || I_CONV_EVT.inj_done || (I_WB_CYC && I_WB_STB && I_WB_WE)))
        else $error("irq rose without end event or write");
    AST_RES_CYCLES: assert property (O_CONV_CFG.min_cycles ==
        O_CONV_CFG.result_bits + CONV_BASE_CYCLES)
        else $error("minimum cycles do not follow resolution");
    AST_RES_SET: assert property (O_CONV_CFG.result_bits inside
        {5'h0c, 5'h0a, 5'h08, 5'h06})
        else $error("illegal result width");
    AST_DISC_LEN: assert property (O_CONV_CFG.disc_len != 4'h0 && O_CONV_CFG.disc_len <= 4'h8)
        else $error("discontinuous length out of range");
    AST_BAT_WINS: assert property (!(O_CONV_CFG.battery_route && O_CONV_CFG.temp_route))
        else $error("battery and temperature routed together");
    AST_HALT_DMA: assert property (O_CONV_CFG.reg_halt |-> !O_CONV_CFG.dma_req)
        else $error("dma request while halted");
    AST_HALT_HOLD: assert property (O_CONV_CFG.reg_halt && !(I_WB_CYC && I_WB_WE)
        |=> O_CONV_CFG.reg_halt)
        else $error("halt dropped without software write");
    AST_AUTO_CAUSE: assert property (O_CONV_CFG.auto_inj_start |->
        $past(I_CONV_EVT.reg_done))
        else $error("auto injected start without regular end");
endmodule
bind asc_status_control asc_status_control_asserts asc_status_control_asserts_inst (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_CONV_EVT(I_CONV_EVT),
    .O_CONV_CFG(O_CONV_CFG), .O_IRQ(O_IRQ));

/* File: asc_status_control_tb.sv */
// Register-level bench for the converter flags, control and interrupt block.
// Assumes the checker is bound separately; the bench plays master and core.
`timescale 1ns/1ps
module asc_status_control_tb
    import asc_pkg::*;
;
    logic        core_clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] got;
    logic        ack;
    logic        irq;
    asc_event_t  evt;
    asc_config_t cfg;
    asc_config_t pcfg;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [11:0] win [3] = '{12'h0ff, 12'h180, 12'h201};

    asc_status_control asc_status_control_inst (
        .I_CORE_CLK(core_clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_CONV_EVT(evt), .O_CONV_CFG(cfg), .O_IRQ(irq));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Run is about 280 cycles; the ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            test_done();
        end
    end

    // ========
    // Tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Holds the request until ack is sampled high; no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do @(posedge core_clk); while (ack !== 1'b1);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(got, e);
    endtask

    task automatic pulse(input logic [6:0] b, input logic [4:0] ch, input logic [11:0] dt);
        @(posedge core_clk);
        evt <= {b, ch, dt};
        @(posedge core_clk);
        evt <= '0;
        @(posedge core_clk);
        // Pulse outputs launched by the event still stand here
        pcfg = cfg;
    endtask

    // ========
    // Sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, sel, wdat} = '0;
        evt = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(FLAGS_OFS, 32'h0);
        rdc(CTRL1_OFS, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(CTRL1_OFS, 32'(c) << 24);
            @(posedge core_clk);
            chk(32'(cfg.result_bits), 32'(12 - 2 * c));
            chk(32'(cfg.min_cycles), 32'(15 - 2 * c));
        end
        for (int c = 0; c < 8; c += 7) begin
            wr(CTRL1_OFS, (32'(c) << 13) | 32'h0000_1900);
            @(posedge core_clk);
            chk(32'(cfg.disc_len), 32'(c + 1));
            chk({29'h0, cfg.scan, cfg.reg_disc, cfg.inj_disc}, 32'h7);
        end
        bus(1'b1, CTRL1_OFS, 32'h0, 4'h3);
        rdc(CTRL1_OFS, 32'h0000_f900);
        wr(CTRL1_OFS, 32'hffff_ffff);
        rdc(CTRL1_OFS, 32'h07c0_ffff);
        wr(CTRL1_OFS, 32'h0400_00e0);
        pulse(7'b1100000, 5'h0, 12'h0);
        rdc(FLAGS_OFS, 32'h18);
        chk({31'h0, irq}, 32'h0);
        wr(FLAGS_OFS, 32'hffff_ffef);
        rdc(FLAGS_OFS, 32'h08);
        wr(FLAGS_OFS, 32'h0);
        pulse(7'b0011000, 5'h2, 12'h5a5);
        rdc(FLAGS_OFS, 32'h02);
        chk({31'h0, irq}, 32'h1);
        rdc(RESULT_OFS, 32'h5a5);
        rdc(FLAGS_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        pulse(7'b0000100, 5'h1, 12'h0);
        rdc(FLAGS_OFS, 32'h0);
        pulse(7'b0000110, 5'h1, 12'h0);
        rdc(FLAGS_OFS, 32'h04);
        chk({31'h0, irq}, 32'h1);
        wr(FLAGS_OFS, 32'h0);
        // Watchdog window 0x100..0x200 on channel 5 only, auto injection on
        wr(LOWTH_OFS, 32'h100);
        wr(HIGHTH_OFS, 32'h200);
        wr(CTRL1_OFS, 32'h0480_06e5);
        pulse(7'b0011000, 5'h3, 12'h300);
        chk({31'h0, pcfg.auto_inj_start}, 32'h1);
        rdc(RESULT_OFS, 32'h300);
        rdc(FLAGS_OFS, 32'h0);
        for (int i = 0; i < 3; i++) begin
            pulse(7'b0011000, 5'h5, win[i]);
            rdc(FLAGS_OFS, (win[i] == 12'h180) ? 32'h2 : 32'h3);
            rdc(RESULT_OFS, {20'h0, win[i]});
            wr(FLAGS_OFS, 32'h0);
        end
        // Injected monitor only, all channels; then a reserved channel code
        wr(CTRL1_OFS, 32'h0040_0000);
        pulse(7'b0000100, 5'h7, 12'h300);
        rdc(FLAGS_OFS, 32'h01);
        wr(FLAGS_OFS, 32'h0);
        pulse(7'b0011000, 5'h7, 12'h300);
        rdc(FLAGS_OFS, 32'h02);
        rdc(RESULT_OFS, 32'h300);
        wr(CTRL1_OFS, 32'h0080_0213);
        pulse(7'b0011000, 5'h13, 12'h300);
        rdc(FLAGS_OFS, 32'h02);
        rdc(RESULT_OFS, 32'h300);
        // Overrun: off without DMA or per-conversion ends, on with DMA
        wr(CTRL1_OFS, 32'h0400_0000);
        pulse(7'b0011000, 5'h0, 12'h001);
        chk({31'h0, pcfg.auto_inj_start}, 32'h0);
        chk({31'h0, pcfg.dma_req}, 32'h0);
        pulse(7'b0011000, 5'h0, 12'h002);
        rdc(FLAGS_OFS, 32'h02);
        rdc(RESULT_OFS, 32'h002);
        wr(MODE_OFS, 32'h100);
        pulse(7'b0011000, 5'h0, 12'h001);
        chk({31'h0, pcfg.dma_req}, 32'h1);
        pulse(7'b0011000, 5'h0, 12'h002);
        chk({31'h0, pcfg.dma_req}, 32'h0);
        rdc(FLAGS_OFS, 32'h22);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, cfg.reg_halt}, 32'h1);
        rdc(RESULT_OFS, 32'h001);
        // Regular start and end are ignored while halted
        pulse(7'b1011000, 5'h0, 12'h003);
        rdc(FLAGS_OFS, 32'h20);
        rdc(RESULT_OFS, 32'h001);
        wr(FLAGS_OFS, 32'h0);
        @(posedge core_clk);
        chk({31'h0, cfg.reg_halt}, 32'h0);
        // Per-conversion ends: end flag without last, overrun without halt
        wr(MODE_OFS, 32'h400);
        pulse(7'b0010000, 5'h0, 12'h004);
        rdc(FLAGS_OFS, 32'h02);
        pulse(7'b0010000, 5'h0, 12'h005);
        rdc(FLAGS_OFS, 32'h22);
        chk({31'h0, cfg.reg_halt}, 32'h0);
        rdc(RESULT_OFS, 32'h004);
        wr(FLAGS_OFS, 32'h0);
        wr(MODE_OFS, 32'h0);
        pulse(7'b0010000, 5'h0, 12'h006);
        rdc(FLAGS_OFS, 32'h0);
        rdc(RESULT_OFS, 32'h006);
        for (int k = 1; k < 4; k++) begin
            wr(COMMON_OFS, 32'(k));
            @(posedge core_clk);
            chk({30'h0, cfg.temp_route, cfg.battery_route}, (k == 2) ? 32'h2 : 32'h1);
        end
        wr(8'h40, 32'hffff_ffff);
        rdc(8'h40, 32'h0);
        test_done();
    end
endmodule
